/* ufc_pkg.sv */
`default_nettype none
// ============================================================
// Shared constants and types of the serial port slice
package ufc_pkg;
    // ============================================================
    // Register offsets
    localparam logic [7:0] OFS_FMT = 8'h00;
    localparam logic [7:0] OFS_CTL = 8'h04;
    localparam logic [7:0] OFS_TXD = 8'h08;
    localparam logic [7:0] OFS_STS = 8'h0C;
    localparam logic [7:0] OFS_RXD = 8'h10;
    localparam logic [7:0] OFS_MSK = 8'h14;
    localparam logic [7:0] OFS_BRR = 8'h18;
    // ============================================================
    // Field positions
    localparam int FMT_STOP = 3;
    localparam int FMT_RSVD = 2;
    localparam int FMT_CKS_HI = 1;
    localparam int FMT_CKS_LO = 0;
    localparam int CTL_TX_IRQ_EN = 7;
    localparam int CTL_TE = 5;
    localparam int CTL_RE = 4;
    localparam int STS_TX_LOW = 0;
    localparam int STS_RDONE = 1;
    localparam int STS_FERR = 2;
    localparam int STS_W = 3;
    // ============================================================
    // Reset values
    localparam logic [1:0] RST_CKS = 2'h0;
    localparam logic [7:0] RST_BRR = 8'h0F;
    localparam logic [STS_W-1:0] RST_STS = 3'h0;
    // ============================================================
    // Prescaler terminal counts: divide by 1, 4, 16, 64
    localparam logic [5:0] PRE_LAST_1 = 6'h00;
    localparam logic [5:0] PRE_LAST_4 = 6'h03;
    localparam logic [5:0] PRE_LAST_16 = 6'h0F;
    localparam logic [5:0] PRE_LAST_64 = 6'h3F;
    // ============================================================
    // Transmit FIFO geometry
    localparam int DATA_W = 8;
    localparam int PTR_W = 4;
    localparam int CNT_W = 5;
    localparam logic [CNT_W-1:0] FIFO_FULL = 5'h10;
    localparam logic [CNT_W-1:0] TX_TRIG = 5'h08;
    localparam logic [2:0] LAST_BIT = 3'h7;

    // Register port request
    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } ufc_bus_t;

    // Gray coded along idle, load, start, data, stop, stop
    typedef enum logic [2:0] {
        TX_IDLE = 3'h0,
        TX_LOAD = 3'h1,
        TX_START = 3'h3,
        TX_DATA = 3'h2,
        TX_STOP1 = 3'h6,
        TX_STOP2 = 3'h7
    } ufc_tx_st_t;

    typedef enum logic [1:0] {
        RX_IDLE = 2'h0,
        RX_START = 2'h1,
        RX_DATA = 2'h3,
        RX_STOP = 2'h2
    } ufc_rx_st_t;

    // Prescaler terminal count for a clock-select code
    function automatic logic [5:0] ufc_pre_last(input logic [1:0] cks);
        case (cks)
            2'h0: return PRE_LAST_1;
            2'h1: return PRE_LAST_4;
            2'h2: return PRE_LAST_16;
            default: return PRE_LAST_64;
        endcase
    endfunction
endpackage
`default_nettype wire

/* ufc_mem.sv */
`timescale 1ns/1ps
`default_nettype none
// ============================================================
// Transmit FIFO storage, registered read data
module ufc_mem (
    input wire logic clk_i,
    input wire logic reset_n_i,
    input wire logic we_i,
    input wire logic [ufc_pkg::PTR_W-1:0] waddr_i,
    input wire logic [ufc_pkg::DATA_W-1:0] wdata_i,
    input wire logic re_i,
    input wire logic [ufc_pkg::PTR_W-1:0] raddr_i,
    output logic [ufc_pkg::DATA_W-1:0] rdata_o
);
    import ufc_pkg::*;

    typedef struct packed {
        logic [(1<<PTR_W)-1:0][DATA_W-1:0] mem;
        logic [DATA_W-1:0] rdata;
    } ufc_mem_st_t;

    ufc_mem_st_t m_q;
    ufc_mem_st_t m_d;

    // Write and read ports
    always_comb begin
        m_d = m_q;
        if (we_i) begin
            m_d.mem[waddr_i] = wdata_i;
        end
        if (re_i) begin
            m_d.rdata = m_q.mem[raddr_i];
        end
    end

    always_ff @(posedge clk_i) begin
        if (!reset_n_i) begin
            m_q <= '0;
        end else begin
            m_q <= m_d;
        end
    end

    assign rdata_o = m_q.rdata;
endmodule
`default_nettype wire

/* ufc_top.sv */
`timescale 1ns/1ps
`default_nettype none
module ufc_top (
    input wire logic clk_i,
    input wire logic reset_n_i,
    input wire ufc_pkg::ufc_bus_t bus_i,
    output logic [7:0] rdata_o,
    input wire logic rxd_i,
    output logic txd_o,
    output logic tx_fifo_low_irq_o,
    output logic irq_o
);
    import ufc_pkg::*;

    // ============================================================
    // State
    typedef struct packed {
        logic [7:0] rdata;
        logic txd;
        logic tx_low_irq;
        logic irq;
        logic stop2;
        logic [1:0] cks;
        logic tx_irq_en;
        logic te;
        logic re;
        logic [7:0] brr;
        logic [STS_W-1:0] sts;
        logic [STS_W-1:0] msk;
        logic [5:0] pre_cnt;
        logic pre_en;
        ufc_tx_st_t tx_st;
        logic [7:0] tx_sh;
        logic [2:0] tx_bit;
        logic [7:0] tx_cnt;
        logic [PTR_W-1:0] wptr;
        logic [PTR_W-1:0] rptr;
        logic [CNT_W-1:0] count;
        ufc_rx_st_t rx_st;
        logic [7:0] rx_sh;
        logic [2:0] rx_bit;
        logic [7:0] rx_cnt;
        logic [7:0] rx_data;
    } ufc_state_t;

    ufc_state_t s_q;
    ufc_state_t s_d;
    logic push;
    logic pop;
    logic tx_tick;
    logic rx_tick;
    logic rx_half;
    logic [DATA_W-1:0] mem_rdata;

    // ============================================================
    // Baud ticks: one prescaled period per count, brr+1 per bit
    assign tx_tick = s_q.pre_en && (s_q.tx_cnt == s_q.brr);
    assign rx_tick = s_q.pre_en && (s_q.rx_cnt == s_q.brr);
    assign rx_half = s_q.pre_en && (s_q.rx_cnt == {1'b0, s_q.brr[7:1]});

    // ============================================================
    // Next state
    always_comb begin
        s_d = s_q;
        push = 1'b0;
        pop = 1'b0;

        // Prescaler; >= keeps it sane when the select shrinks mid-count
        s_d.pre_en = 1'b0;
        if (s_q.pre_cnt >= ufc_pre_last(s_q.cks)) begin
            s_d.pre_cnt = 6'h00;
            s_d.pre_en = 1'b1;
        end else begin
            s_d.pre_cnt = s_q.pre_cnt + 6'h01;
        end

        // Register writes, accepted whatever the line is doing
        if (bus_i.wr) begin
            case (bus_i.addr)
                OFS_FMT: begin
                    s_d.stop2 = bus_i.wdata[FMT_STOP];
                    s_d.cks = bus_i.wdata[FMT_CKS_HI:FMT_CKS_LO];
                end
                OFS_CTL: begin
                    s_d.tx_irq_en = bus_i.wdata[CTL_TX_IRQ_EN];
                    s_d.te = bus_i.wdata[CTL_TE];
                    s_d.re = bus_i.wdata[CTL_RE];
                end
                OFS_TXD: begin
                    // Full FIFO drops the byte silently
                    push = (s_q.count != FIFO_FULL);
                end
                OFS_STS: s_d.sts = s_q.sts & ~bus_i.wdata[STS_W-1:0];
                OFS_MSK: s_d.msk = bus_i.wdata[STS_W-1:0];
                OFS_BRR: s_d.brr = bus_i.wdata;
                default: ;
            endcase
        end
        if (push) begin
            s_d.wptr = s_q.wptr + 4'h1;
        end

        // Register reads, data valid in the next cycle only
        s_d.rdata = 8'h00;
        if (bus_i.rd) begin
            case (bus_i.addr)
                OFS_FMT: begin
                    s_d.rdata[FMT_STOP] = s_q.stop2;
                    s_d.rdata[FMT_RSVD] = 1'b0;
                    s_d.rdata[FMT_CKS_HI:FMT_CKS_LO] = s_q.cks;
                end
                OFS_CTL: begin
                    s_d.rdata[CTL_TX_IRQ_EN] = s_q.tx_irq_en;
                    s_d.rdata[CTL_TE] = s_q.te;
                    s_d.rdata[CTL_RE] = s_q.re;
                end
                OFS_STS: s_d.rdata[STS_W-1:0] = s_q.sts;
                OFS_RXD: s_d.rdata = s_q.rx_data;
                OFS_MSK: s_d.rdata[STS_W-1:0] = s_q.msk;
                OFS_BRR: s_d.rdata = s_q.brr;
                default: s_d.rdata = 8'h00;
            endcase
        end

        // Transmitter
        if (s_q.pre_en) begin
            s_d.tx_cnt = tx_tick ? 8'h00 : s_q.tx_cnt + 8'h01;
        end
        case (s_q.tx_st)
            TX_IDLE: begin
                s_d.txd = 1'b1;
                if (s_q.te && (s_q.count != '0)) begin
                    pop = 1'b1;
                    s_d.rptr = s_q.rptr + 4'h1;
                    s_d.tx_st = TX_LOAD;
                end
            end
            TX_LOAD: begin
                // Memory read data arrive one cycle after the pop
                s_d.tx_sh = mem_rdata;
                s_d.tx_cnt = 8'h00;
                s_d.tx_bit = 3'h0;
                s_d.txd = 1'b0;
                s_d.tx_st = TX_START;
            end
            TX_START: begin
                if (tx_tick) begin
                    s_d.txd = s_q.tx_sh[0];
                    s_d.tx_sh = {1'b0, s_q.tx_sh[7:1]};
                    s_d.tx_st = TX_DATA;
                end
            end
            TX_DATA: begin
                if (tx_tick) begin
                    if (s_q.tx_bit == LAST_BIT) begin
                        s_d.txd = 1'b1;
                        s_d.tx_st = TX_STOP1;
                    end else begin
                        s_d.txd = s_q.tx_sh[0];
                        s_d.tx_sh = {1'b0, s_q.tx_sh[7:1]};
                        s_d.tx_bit = s_q.tx_bit + 3'h1;
                    end
                end
            end
            TX_STOP1: begin
                s_d.txd = 1'b1;
                if (tx_tick) begin
                    s_d.tx_st = s_q.stop2 ? TX_STOP2 : TX_IDLE;
                end
            end
            TX_STOP2: begin
                s_d.txd = 1'b1;
                if (tx_tick) begin
                    s_d.tx_st = TX_IDLE;
                end
            end
            default: begin
                s_d.txd = 1'b1;
                s_d.tx_st = TX_IDLE;
            end
        endcase
        s_d.count = s_q.count + {4'h0, push} - {4'h0, pop};

        // Receiver; stop setting is deliberately ignored here
        if (s_q.pre_en) begin
            s_d.rx_cnt = rx_tick ? 8'h00 : s_q.rx_cnt + 8'h01;
        end
        case (s_q.rx_st)
            RX_IDLE: begin
                // A low second stop bit lands here as a start bit
                if (s_q.re && !rxd_i) begin
                    s_d.rx_cnt = 8'h00;
                    s_d.rx_st = RX_START;
                end
            end
            RX_START: begin
                if (rx_half) begin
                    s_d.rx_cnt = 8'h00;
                    s_d.rx_bit = 3'h0;
                    s_d.rx_st = rxd_i ? RX_IDLE : RX_DATA;
                end
            end
            RX_DATA: begin
                if (rx_tick) begin
                    s_d.rx_sh = {rxd_i, s_q.rx_sh[7:1]};
                    s_d.rx_bit = s_q.rx_bit + 3'h1;
                    if (s_q.rx_bit == LAST_BIT) begin
                        s_d.rx_st = RX_STOP;
                    end
                end
            end
            RX_STOP: begin
                if (rx_tick) begin
                    if (rxd_i) begin
                        s_d.rx_data = s_q.rx_sh;
                        s_d.sts[STS_RDONE] = 1'b1;
                    end else begin
                        s_d.sts[STS_FERR] = 1'b1;
                    end
                    s_d.rx_st = RX_IDLE;
                end
            end
            default: s_d.rx_st = RX_IDLE;
        endcase

        // FIFO-low flag; set after the clear so a same-cycle event wins
        if (pop && (s_d.count < TX_TRIG)) begin
            s_d.sts[STS_TX_LOW] = 1'b1;
        end

        // Interrupt outputs from the next state so they track the flags
        s_d.tx_low_irq = s_d.tx_irq_en && s_d.sts[STS_TX_LOW];
        s_d.irq = |(s_d.sts & s_d.msk);
    end

    // ============================================================
    // State register
    always_ff @(posedge clk_i) begin
        if (!reset_n_i) begin
            s_q <= '0;
            s_q.txd <= 1'b1;
            s_q.cks <= RST_CKS;
            s_q.brr <= RST_BRR;
            s_q.sts <= RST_STS;
            s_q.tx_st <= TX_IDLE;
            s_q.rx_st <= RX_IDLE;
        end else begin
            s_q <= s_d;
        end
    end

    ufc_mem u_mem (
        .clk_i(clk_i),
        .reset_n_i(reset_n_i),
        .we_i(push),
        .waddr_i(s_q.wptr),
        .wdata_i(bus_i.wdata),
        .re_i(pop),
        .raddr_i(s_q.rptr),
        .rdata_o(mem_rdata)
    );

    assign rdata_o = s_q.rdata;
    assign txd_o = s_q.txd;
    assign tx_fifo_low_irq_o = s_q.tx_low_irq;
    assign irq_o = s_q.irq;

    // ============================================================
    // Checks
    default clocking @(posedge clk_i);
    endclocking
    default disable iff (!reset_n_i);

    property p_stop_one;
        (s_q.tx_st == TX_STOP1 && tx_tick && !s_q.stop2)
            |=> (s_q.tx_st == TX_IDLE) && txd_o;
    endproperty
    a_stop_one: assert property (p_stop_one)
        else $error("one stop bit not ended after one bit");

    property p_stop_two;
        (s_q.tx_st == TX_STOP1 && tx_tick && s_q.stop2)
            |=> (s_q.tx_st == TX_STOP2) && txd_o;
    endproperty
    a_stop_two: assert property (p_stop_two)
        else $error("second stop bit missing");

    property p_stop_high;
        (s_q.tx_st == TX_STOP1 || s_q.tx_st == TX_STOP2) |-> txd_o;
    endproperty
    a_stop_high: assert property (p_stop_high)
        else $error("line low during stop bits");

    property p_rx_one_stop;
        (s_q.rx_st == RX_STOP && rx_tick) |=> (s_q.rx_st == RX_IDLE);
    endproperty
    a_rx_one_stop: assert property (p_rx_one_stop)
        else $error("receiver waited past first stop bit");

    property p_rx_restart;
        (s_q.rx_st == RX_IDLE && s_q.re && !rxd_i) |=> (s_q.rx_st == RX_START);
    endproperty
    a_rx_restart: assert property (p_rx_restart)
        else $error("low line in idle not taken as start");

    property p_fmt_rsvd;
        (bus_i.rd && bus_i.addr == OFS_FMT) |=> !rdata_o[FMT_RSVD];
    endproperty
    a_fmt_rsvd: assert property (p_fmt_rsvd)
        else $error("reserved format bit read as one");

    sequence s_div4_start;
        s_q.pre_en && (s_q.cks == 2'h1);
    endsequence
    sequence s_div4_gap;
        (!s_q.pre_en && (s_q.cks == 2'h1)) [*3];
    endsequence
    property p_div4;
        s_div4_start ##1 s_div4_gap |=> s_q.pre_en;
    endproperty
    a_div4: assert property (p_div4)
        else $error("divide by four period wrong");

    property p_low_irq_set;
        (s_q.tx_irq_en && pop && !push && s_q.count <= TX_TRIG
            && !(bus_i.wr && bus_i.addr == OFS_CTL)) |=> tx_fifo_low_irq_o;
    endproperty
    a_low_irq_set: assert property (p_low_irq_set)
        else $error("FIFO-low interrupt not raised");

    property p_low_irq_off;
        !s_q.tx_irq_en |-> !tx_fifo_low_irq_o;
    endproperty
    a_low_irq_off: assert property (p_low_irq_off)
        else $error("transmit interrupt while disabled");

    property p_ctl_write;
        (bus_i.wr && bus_i.addr == OFS_CTL)
            |=> (s_q.tx_irq_en == $past(bus_i.wdata[CTL_TX_IRQ_EN]));
    endproperty
    a_ctl_write: assert property (p_ctl_write)
        else $error("control write lost");

    property p_reset_vals;
        $rose(reset_n_i) |-> (!s_q.stop2 && s_q.cks == 2'h0 && !s_q.tx_irq_en);
    endproperty
    a_reset_vals: assert property (p_reset_vals)
        else $error("control fields not zero after reset");
endmodule
`default_nettype wire

/* ufc_remote.sv */
`timescale 1ns/1ps
`default_nettype none
// ============================================================
// Far-end serial transceiver on the line
module ufc_remote (
    input wire logic clk_i,
    input wire logic txd_i,
    output logic rxd_o
);
    // The line rests high between characters
    initial begin
        rxd_o = 1'b1;
    end

    // One character, LSB first; extra high bit times follow the stop bit
    task automatic send(input logic [7:0] data, input logic stop_lvl, input int extra,
                        input int bit_cyc);
        logic [9:0] frame;
        frame = {stop_lvl, data, 1'b0};
        for (int i = 0; i < 10; i++) begin
            rxd_o <= frame[i];
            repeat (bit_cyc) @(posedge clk_i);
        end
        // With no extra time the next start follows the stop directly
        if (extra > 0) begin
            rxd_o <= 1'b1;
            repeat (extra * bit_cyc) @(posedge clk_i);
        end
    endtask

    // Samples at mid-bit; gap runs from mid of bit 7 to the next low level
    task automatic recv(input int bit_cyc, output logic [7:0] data, output int gap);
        while (txd_i !== 1'b0) @(posedge clk_i);
        repeat (bit_cyc / 2) @(posedge clk_i);
        for (int i = 0; i < 8; i++) begin
            repeat (bit_cyc) @(posedge clk_i);
            data[i] = txd_i;
        end
        gap = 0;
        // Bit 7 may itself be low, so wait for the stop level first
        while (txd_i !== 1'b1 && gap < 4 * bit_cyc) begin
            @(posedge clk_i);
            gap++;
        end
        // Bounded so a lone character does not hang the far end
        while (txd_i !== 1'b0 && gap < 4 * bit_cyc) begin
            @(posedge clk_i);
            gap++;
        end
    endtask
endmodule
`default_nettype wire

/* ufc_top_test.sv */
`timescale 1ns/1ps
`default_nettype none
// ============================================================
// Self-checking bench of the serial port slice
module ufc_top_test;
    import ufc_pkg::*;
    logic clk;
    logic reset_n;
    logic rxd;
    logic txd;
    logic tx_irq;
    logic irq;
    logic [7:0] rdata;
    ufc_bus_t bus;
    int errors;
    int check_count;

    ufc_top u_dut (
        .clk_i(clk),
        .reset_n_i(reset_n),
        .bus_i(bus),
        .rdata_o(rdata),
        .rxd_i(rxd),
        .txd_o(txd),
        .tx_fifo_low_irq_o(tx_irq),
        .irq_o(irq)
    );

    ufc_remote u_remote (
        .clk_i(clk),
        .txd_i(txd),
        .rxd_o(rxd)
    );

    // ============================================================
    // Shared helpers
    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        check_count++;
        if (got !== exp) begin
            errors++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask

    // A spare cycle after each strobe keeps one assignment per time step
    task automatic wr(input logic [7:0] addr, input logic [7:0] data);
        bus <= '{wr: 1'b1, rd: 1'b0, addr: addr, wdata: data};
        @(posedge clk);
        bus <= '0;
        @(posedge clk);
    endtask

    task automatic rd(input logic [7:0] addr, output logic [7:0] data);
        bus <= '{wr: 1'b0, rd: 1'b1, addr: addr, wdata: 8'h00};
        @(posedge clk);
        bus <= '0;
        #1 data = rdata;
        @(posedge clk);
    endtask

    task automatic rd_chk(input logic [7:0] addr, input logic [7:0] exp, input string what);
        logic [7:0] d;
        rd(addr, d);
        chk(what, exp, d);
    endtask

    task automatic poll_flag(output int n);
        logic [7:0] d;
        n = 0;
        d = 8'h00;
        while (d[0] !== 1'b1 && n < 400) begin
            rd(OFS_STS, d);
            n++;
        end
    endtask

    task automatic finish_test();
        $display("checks %0d mismatches %0d", check_count, errors);
        if (errors == 0 && check_count > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    // ============================================================
    // Scenarios
    task automatic test_reset();
        chk("txd idle", 8'h01, {7'h0, txd});
        chk("tx irq idle", 8'h00, {7'h0, tx_irq});
        rd_chk(OFS_FMT, 8'h00, "format reset");
        rd_chk(OFS_CTL, 8'h00, "control reset");
        $display("test_reset done");
    endtask

    // Reserved bit 2 is always written zero; it must still read zero beside set bits
    task automatic test_regs();
        wr(OFS_FMT, 8'h0B);
        rd_chk(OFS_FMT, 8'h0B, "format readback");
        wr(OFS_FMT, 8'h00);
        wr(OFS_CTL, 8'hFF);
        rd_chk(OFS_CTL, 8'hB0, "control readback");
        wr(OFS_CTL, 8'h00);
        rd_chk(8'h1C, 8'h00, "unmapped read");
        $display("test_regs done");
    endtask

    // Two queued characters expose the stop length as the gap between them
    task automatic test_stop();
        logic [7:0] d;
        int gap;
        for (int s = 0; s < 2; s++) begin
            wr(OFS_FMT, 8'(s << 3));
            wr(OFS_TXD, 8'h35);
            wr(OFS_TXD, 8'h4A);
            wr(OFS_CTL, 8'h20);
            u_remote.recv(16, d, gap);
            chk("first char", 8'h35, d);
            chk("stop gap low", 8'h01, 8'(gap >= (s + 1) * 16 + 7));
            chk("stop gap high", 8'h01, 8'(gap < (s + 1) * 16 + 16));
            u_remote.recv(16, d, gap);
            chk("second char", 8'h4A, d);
            wr(OFS_CTL, 8'h00);
        end
        $display("test_stop done");
    endtask

    // Mid-bit sampling only lands if the bit time matches the divider
    task automatic test_prescale();
        logic [7:0] d;
        int gap;
        wr(OFS_BRR, 8'h03);
        wr(OFS_CTL, 8'h20);
        for (int c = 0; c < 4; c++) begin
            wr(OFS_FMT, 8'(c));
            wr(OFS_TXD, 8'h35 + 8'(c));
            u_remote.recv(4 << (2 * c), d, gap);
            chk("prescaled char", 8'h35 + 8'(c), d);
        end
        wr(OFS_CTL, 8'h00);
        wr(OFS_FMT, 8'h00);
        wr(OFS_BRR, 8'h0F);
        $display("test_prescale done");
    endtask

    task automatic test_rx();
        logic [7:0] d;
        wr(OFS_CTL, 8'h10);
        wr(OFS_FMT, 8'h08);
        wr(OFS_STS, 8'h07);
        u_remote.send(8'hA5, 1'b1, 0, 16);
        // Next start follows the first stop bit with no idle
        fork
            u_remote.send(8'h3C, 1'b1, 1, 16);
            rd_chk(OFS_RXD, 8'hA5, "rx first");
        join
        rd_chk(OFS_RXD, 8'h3C, "rx back to back");
        rd_chk(OFS_STS, 8'h02, "rx status");
        wr(OFS_STS, 8'h07);
        u_remote.send(8'h11, 1'b0, 1, 16);
        repeat (200) @(posedge clk);
        rd(OFS_STS, d);
        chk("framing error", 8'h04, d & 8'h04);
        wr(OFS_CTL, 8'h00);
        wr(OFS_FMT, 8'h00);
        $display("test_rx done");
    endtask

    // Nine bytes queued: the first pop leaves eight, the second seven
    task automatic test_irq();
        int n;
        for (int i = 0; i < 9; i++) begin
            wr(OFS_TXD, 8'(i));
        end
        wr(OFS_STS, 8'h07);
        wr(OFS_CTL, 8'h20);
        poll_flag(n);
        chk("no flag on first pop", 8'h01, 8'(n > 60));
        chk("tx irq while disabled", 8'h00, {7'h0, tx_irq});
        chk("irq masked", 8'h00, {7'h0, irq});
        wr(OFS_MSK, 8'h01);
        chk("irq unmasked", 8'h01, {7'h0, irq});
        wr(OFS_CTL, 8'hA0);
        chk("tx irq enabled", 8'h01, {7'h0, tx_irq});
        rd_chk(OFS_CTL, 8'hA0, "control while busy");
        wr(OFS_STS, 8'h01);
        chk("tx irq cleared", 8'h00, {7'h0, tx_irq});
        chk("irq cleared", 8'h00, {7'h0, irq});
        poll_flag(n);
        chk("tx irq next pop", 8'h01, {7'h0, tx_irq});
        wr(OFS_CTL, 8'h20);
        chk("tx irq disabled", 8'h00, {7'h0, tx_irq});
        chk("irq still set", 8'h01, {7'h0, irq});
        repeat (1500) @(posedge clk);
        wr(OFS_MSK, 8'h00);
        wr(OFS_STS, 8'h07);
        wr(OFS_CTL, 8'h00);
        $display("test_irq done");
    endtask

    // ============================================================
    // Clock, watchdog and main sequence
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    // Whole run needs about 8000 cycles
    initial begin
        repeat (40000) @(posedge clk);
        errors++;
        $display("MISMATCH watchdog expected done seen hang");
        finish_test();
    end

    initial begin
        errors = 0;
        check_count = 0;
        reset_n = 1'b0;
        bus = '0;
        repeat (10) @(posedge clk);
        reset_n <= 1'b1;
        repeat (2) @(posedge clk);
        test_reset();
        test_regs();
        test_stop();
        test_prescale();
        test_rx();
        test_irq();
        finish_test();
    end
endmodule
`default_nettype wire
